// >>> logic/mace_engine.sv
// Multiply accumulate engine: 16x16 signed multiplier, 40-bit accumulator,
// one-bit arithmetic shifter and rounding with optional saturation.
// Assumes every write strobe comes from logic on core_clk, one cycle long.
`timescale 1ns/1ps
`include "mace_defs.svh"

module mace_engine
(
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         rstn,
   // Configuration write
   input  wire logic                         cfg_wr,
   input  wire mace_pkg::mace_cfg_type       cfg_wdata,
   // Operand writes
   input  wire mace_pkg::mace_opnd_wr_type   opnd_wr,
   // Accumulator byte writes
   input  wire mace_pkg::mace_acc_wr_type    acc_wr,
   // Register views
   output mace_pkg::mace_cfg_type            engine_config,
   output mace_pkg::mace_flags_type          engine_flags,
   output logic [`MACE_OPND_W-1:0]           operand_a,
   output logic [`MACE_OPND_W-1:0]           operand_b,
   output logic [`MACE_ACC_W-1:0]            accumulator,
   output logic [`MACE_RND_W-1:0]            rounded_result,
   // Pipeline state
   output logic                              busy
);
   import mace_pkg::*;

   // ======================================================================
   // Declarations
   // ======================================================================
   mace_cfg_type              cfg_reg;
   mace_flags_type            flags_reg;
   logic [`MACE_OPND_W-1:0]   opa_reg;
   logic [`MACE_OPND_W-1:0]   opb_reg;
   logic [`MACE_ACC_W-1:0]    acc_reg;
   logic [`MACE_ACC_W-1:0]    acc_next;
   logic [`MACE_ACC_W-1:0]    prod_reg;
   logic                      stage1_reg;
   logic                      stage2_reg;
   logic                      mult_only_reg;
   logic                      clear_now_reg;
   logic                      shift_done_reg;
   logic                      byte0_wr_reg;
   logic                      start;
   logic                      clear_start;
   logic                      shift_go;
   logic                      round_update;
   logic [`MACE_OPND_W-1:0]   opb_next;
   logic signed [`MACE_PROD_W-1:0] prod_raw;
   logic [`MACE_ACC_W-1:0]    prod_scaled;
   logic [`MACE_ACC_W-1:0]    prod_ext;
   logic [`MACE_ACC_W-1:0]    addend;
   logic [`MACE_ACC_W:0]      sum_wide;
   logic [`MACE_ACC_W-1:0]    sum;
   logic                      hi_over;
   logic                      lo_over;
   logic [`MACE_ACC_W-1:0]    acc_shifted;
   logic [`MACE_ACC_W-1:0]    acc_bytes;

   // ======================================================================
   // Start and command decode
   // ======================================================================
   // Operation starts on the low byte of operand B
   assign start       = opnd_wr.operand_b_low_wr;
   assign clear_start = start && cfg_reg.clear_accumulator;
   assign shift_go    = cfg_reg.shift_command;
   // Low byte of B joins the stored high byte in the start cycle
   assign opb_next    = {opb_reg[`MACE_OPND_W-1:`MACE_BYTE_W], opnd_wr.operand_b_byte};

   // ======================================================================
   // Operand registers
   // ======================================================================
   // Operand A, loaded whole
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         opa_reg <= `MACE_OPND_RST;
      end
      else if (opnd_wr.operand_a_wr)
      begin
         opa_reg <= opnd_wr.operand_a;
      end
   end

   // Operand B, loaded a byte at a time
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         opb_reg <= `MACE_OPND_RST;
      end
      else if (opnd_wr.operand_b_high_wr)
      begin
         opb_reg[`MACE_OPND_W-1:`MACE_BYTE_W] <= opnd_wr.operand_b_byte;
      end
      else if (opnd_wr.operand_b_low_wr)
      begin
         opb_reg <= opb_next;
      end
   end

   // ======================================================================
   // Configuration register with self-clearing command bits
   // ======================================================================
   // A software write in the same cycle wins over a self-clear
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         cfg_reg <= '0;
      end
      else if (cfg_wr)
      begin
         cfg_reg <= cfg_wdata;
      end
      else
      begin
         if (clear_start)
         begin
            cfg_reg.clear_accumulator <= 1'b0;
         end
         if (shift_go)
         begin
            cfg_reg.shift_command <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Stage one: multiply
   // ======================================================================
   // Signed product of the current operands
   always_comb
   begin
      prod_raw = $signed(opa_reg) * $signed(opnd_wr.operand_b_low_wr ? opb_next : opb_reg);
      // Extend before scaling so a fraction product of +1.0 keeps its sign
      prod_ext = {{(`MACE_ACC_W-`MACE_PROD_W){prod_raw[`MACE_PROD_W-1]}}, prod_raw};
      // Fractions carry one extra sign bit; drop it to put the point at 31/30
      if (cfg_reg.fractional_select)
      begin
         prod_scaled = {prod_ext[`MACE_ACC_W-2:0], 1'b0};
      end
      else
      begin
         prod_scaled = prod_ext;
      end
   end

   // Product and mode latched as the operation enters stage one
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         prod_reg      <= `MACE_ACC_RST;
         mult_only_reg <= 1'b0;
      end
      else if (start)
      begin
         prod_reg      <= prod_scaled;
         mult_only_reg <= cfg_reg.multiply_only_select;
      end
   end

   // Pipeline valid bits; a start is taken while stage two runs
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         stage1_reg    <= 1'b0;
         stage2_reg    <= 1'b0;
         clear_now_reg <= 1'b0;
      end
      else
      begin
         stage1_reg    <= start;
         stage2_reg    <= stage1_reg;
         clear_now_reg <= clear_start;
      end
   end

   // ======================================================================
   // Stage two: accumulate
   // ======================================================================
   // Sign-extended product plus either the accumulator or zero
   always_comb
   begin
      if (mult_only_reg || clear_now_reg)
      begin
         addend = `MACE_ACC_RST;
      end
      else
      begin
         addend = acc_reg;
      end
      sum_wide = {addend[`MACE_ACC_SIGN], addend} + {prod_reg[`MACE_ACC_SIGN], prod_reg};
      sum      = sum_wide[`MACE_ACC_W-1:0];
      // Signed overflow out of the full 40 bits
      hi_over  = sum_wide[`MACE_ACC_W] != sum_wide[`MACE_ACC_SIGN];
      // Result no longer fits the 32-bit word below the top byte
      lo_over  = (sum[`MACE_ACC_SIGN:`MACE_ACC_LOW_SIGN] != `MACE_TOP_ZERO) &&
                 (sum[`MACE_ACC_SIGN:`MACE_ACC_LOW_SIGN] != `MACE_TOP_ONES);
   end

   // ======================================================================
   // Shifter and byte writes
   // ======================================================================
   // One-bit arithmetic shift
   always_comb
   begin
      if (cfg_reg.shift_direction)
      begin
         acc_shifted = {acc_reg[`MACE_ACC_SIGN], acc_reg[`MACE_ACC_SIGN:1]};
      end
      else
      begin
         acc_shifted = {acc_reg[`MACE_ACC_SIGN-1:0], 1'b0};
      end
   end

   // Per-byte merge of software writes into the accumulator
   genvar gi;
   generate
      for (gi = 0; gi < `MACE_ACC_BYTES; gi = gi + 1)
      begin : g_acc_byte
         assign acc_bytes[gi*`MACE_BYTE_W +: `MACE_BYTE_W] =
            acc_wr.byte_wr[gi] ? acc_wr.byte_data
                               : acc_reg[gi*`MACE_BYTE_W +: `MACE_BYTE_W];
      end
   endgenerate

   // Next accumulator: add, then clear, then shift, then byte write
   always_comb
   begin
      if (stage1_reg)
      begin
         acc_next = sum;
      end
      else if (clear_start)
      begin
         acc_next = `MACE_ACC_RST;
      end
      else if (shift_go)
      begin
         acc_next = acc_shifted;
      end
      else
      begin
         acc_next = acc_bytes;
      end
   end

   // Accumulator register
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         acc_reg <= `MACE_ACC_RST;
      end
      else
      begin
         acc_reg <= acc_next;
      end
   end

   // ======================================================================
   // Status flags
   // ======================================================================
   // Overflow flags are sticky until a clear; shifts leave all flags alone
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         flags_reg <= '0;
      end
      else if (stage1_reg)
      begin
         flags_reg.negative_flag <= sum[`MACE_ACC_SIGN];
         flags_reg.zero_flag     <= (sum == `MACE_ACC_RST);
         // Stage two clearing the flags still reports this result
         flags_reg.overflow_flag <= lo_over ||
                                    (flags_reg.overflow_flag && !clear_now_reg);
         if (!mult_only_reg)
         begin
            flags_reg.high_overflow_flag <= hi_over ||
               (flags_reg.high_overflow_flag && !clear_now_reg);
         end
         else if (clear_now_reg)
         begin
            flags_reg.high_overflow_flag <= 1'b0;
         end
      end
      else if (clear_start)
      begin
         flags_reg <= '0;
      end
   end

   // ======================================================================
   // Stage three and other rounding triggers
   // ======================================================================
   // Stage-three, post-shift and byte0-write update strobes
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         shift_done_reg <= 1'b0;
         byte0_wr_reg   <= 1'b0;
      end
      else
      begin
         shift_done_reg <= shift_go && !stage1_reg && !clear_start;
         byte0_wr_reg   <= acc_wr.byte_wr[0] && !stage1_reg && !clear_start && !shift_go;
      end
   end

   assign round_update = stage2_reg || shift_done_reg || byte0_wr_reg;

   // Rounding unit, reads the accumulator and the saturation enable bit
   mace_round u_round
   (
      .core_clk          (core_clk),
      .rstn              (rstn),
      .acc               (acc_reg),
      .saturation_enable (cfg_reg.saturation_enable),
      .update            (round_update),
      .rounded_result    (rounded_result)
   );

   // ======================================================================
   // Register views
   // ======================================================================
   assign engine_config = cfg_reg;
   assign engine_flags  = flags_reg;
   assign operand_a     = opa_reg;
   assign operand_b     = opb_reg;
   assign accumulator   = acc_reg;
   assign busy          = stage1_reg || stage2_reg || shift_go;

endmodule

// >>> logic/mace_defs.svh
// Constants for the multiply accumulate engine: widths, field positions,
// reset values and rounding figures.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef MACE_DEFS_SVH
`define MACE_DEFS_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define MACE_OPND_W        16
`define MACE_PROD_W        32
`define MACE_ACC_W         40
`define MACE_BYTE_W        8
`define MACE_ACC_BYTES     5
`define MACE_RND_W         16

// ==========================================================================
// Accumulator field positions
// ==========================================================================
`define MACE_ACC_SIGN      39
`define MACE_ACC_RND_HI    31
`define MACE_ACC_RND_LO    16
`define MACE_ACC_FRAC_HI   15
`define MACE_ACC_LOW_SIGN  31
`define MACE_ACC_TOP_LO    32

// ==========================================================================
// Reset and constant values
// ==========================================================================
`define MACE_ACC_RST       40'h00_0000_0000
`define MACE_PROD_RST      32'h0000_0000
`define MACE_OPND_RST      16'h0000
`define MACE_RND_RST       16'h0000
`define MACE_RND_HALF      16'h8000
`define MACE_SAT_POS       16'h7fff
`define MACE_SAT_NEG       16'h8000
`define MACE_TOP_ONES      9'h1ff
`define MACE_TOP_ZERO      9'h000

`endif

// >>> logic/mace_pkg.sv
// Types shared by the multiply accumulate engine, its checker and its core model.
// Assumes mace_defs.svh is on the include path.
`include "mace_defs.svh"

package mace_pkg;

   // =======================================================================
   // Configuration bits, most significant first
   // =======================================================================
   typedef struct packed {
      logic shift_command;
      logic shift_direction;
      logic clear_accumulator;
      logic saturation_enable;
      logic fractional_select;
      logic multiply_only_select;
   } mace_cfg_type;

   // =======================================================================
   // Status flags, most significant first
   // =======================================================================
   typedef struct packed {
      logic high_overflow_flag;
      logic zero_flag;
      logic overflow_flag;
      logic negative_flag;
   } mace_flags_type;

   // =======================================================================
   // Operand register write strobes with their data
   // =======================================================================
   typedef struct packed {
      logic                      operand_a_wr;
      logic                      operand_b_high_wr;
      logic                      operand_b_low_wr;
      logic [`MACE_OPND_W-1:0]   operand_a;
      logic [`MACE_BYTE_W-1:0]   operand_b_byte;
   } mace_opnd_wr_type;

   // =======================================================================
   // Accumulator byte writes: one strobe per byte, byte 4 is the top byte
   // =======================================================================
   typedef struct packed {
      logic [`MACE_ACC_BYTES-1:0] byte_wr;
      logic [`MACE_BYTE_W-1:0]    byte_data;
   } mace_acc_wr_type;

endpackage

// >>> logic/mace_round.sv
// Rounding and saturation unit of the multiply accumulate engine.
// Assumes the accumulator is stable in the cycle its update strobe is high.
`timescale 1ns/1ps
`include "mace_defs.svh"

module mace_round
(
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rstn,
   // Accumulator view and control
   input  wire logic [`MACE_ACC_W-1:0]  acc,
   input  wire logic                    saturation_enable,
   input  wire logic                    update,
   // Rounded result
   output logic      [`MACE_RND_W-1:0]  rounded_result
);
   import mace_pkg::*;

   logic [`MACE_RND_W-1:0] frac_part;
   logic [`MACE_RND_W-1:0] mid_part;
   logic                   round_up;
   logic [24:0]            wide_sum;
   logic                   pos_over;
   logic                   neg_over;
   logic [`MACE_RND_W-1:0] rounded_next;

   // ======================================================================
   // Unbiased round of the middle word, ties go to even
   // ======================================================================
   always_comb
   begin
      frac_part = acc[`MACE_ACC_FRAC_HI:0];
      mid_part  = acc[`MACE_ACC_RND_HI:`MACE_ACC_RND_LO];
      round_up  = (frac_part > `MACE_RND_HALF) ||
                  ((frac_part == `MACE_RND_HALF) && acc[`MACE_ACC_RND_LO]);
      wide_sum  = {acc[`MACE_ACC_SIGN], acc[`MACE_ACC_SIGN:`MACE_ACC_RND_LO]}
                  + {24'h00_0000, round_up};
      // Overflow once the rounded value leaves the signed 16-bit range
      pos_over  = !wide_sum[24] && (wide_sum[23:15] != `MACE_TOP_ZERO);
      neg_over  = wide_sum[24] && (wide_sum[23:15] != `MACE_TOP_ONES);
      if (saturation_enable && pos_over)
      begin
         rounded_next = `MACE_SAT_POS;
      end
      else if (saturation_enable && neg_over)
      begin
         rounded_next = `MACE_SAT_NEG;
      end
      else
      begin
         rounded_next = wide_sum[`MACE_RND_W-1:0];
      end
   end

   // ======================================================================
   // Result register, written only on an update strobe
   // ======================================================================
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         rounded_result <= `MACE_RND_RST;
      end
      else if (update)
      begin
         rounded_result <= rounded_next;
      end
   end

endmodule

// >>> verif/mace_engine_props.sv
// Port-level timing checker for the multiply accumulate engine.
// Assumes one clock with synchronous active-low reset; bound below.
`timescale 1ns/1ps
module mace_engine_props
(
   // Clock and reset
   input wire logic                       core_clk,
   input wire logic                       rstn,
   // Writes
   input wire logic                       cfg_wr,
   input wire mace_pkg::mace_cfg_type     cfg_wdata,
   input wire mace_pkg::mace_opnd_wr_type opnd_wr,
   input wire mace_pkg::mace_acc_wr_type  acc_wr,
   // Register views
   input wire mace_pkg::mace_cfg_type     engine_config,
   input wire mace_pkg::mace_flags_type   engine_flags,
   input wire logic [15:0]                operand_a,
   input wire logic [15:0]                operand_b,
   input wire logic [39:0]                accumulator,
   input wire logic [15:0]                rounded_result,
   input wire logic                       busy
);
   import mace_pkg::*;
   logic               start;
   logic signed [31:0] p;
   logic [39:0]        prod;
   // ==========================
   // Expected product of a start
   // ==========================
   assign start = opnd_wr.operand_b_low_wr;
   assign p     = $signed(operand_a) * $signed({operand_b[15:8], opnd_wr.operand_b_byte});
   assign prod  = {{8{p[31]}}, p} << engine_config.fractional_select;
   // Rounding with ties to even and optional saturation
   function automatic logic [15:0] rnd(input logic [39:0] a, input logic sat);
      logic [24:0] v;
      v = {a[39], a[39:16]} + 25'(a[15:0] > 16'h8000 || (a[15:0] == 16'h8000 && a[16]));
      if (sat && !v[24] && |v[23:15])
         return 16'h7fff;
      if (sat && v[24] && !(&v[23:15]))
         return 16'h8000;
      return v[15:0];
   endfunction
   // ==========================
   // Assertions
   // ==========================
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   chk_start_busy: assert property (start |=> busy)
      else $error("busy not raised after start");
   chk_mul_only: assert property (start && engine_config.multiply_only_select
      |-> ##2 accumulator == $past(prod, 2)) else $error("product not in accumulator");
   chk_mac_sum: assert property (start && !engine_config.multiply_only_select
      && !engine_config.clear_accumulator |-> ##2 accumulator == $past(accumulator) + $past(prod, 2))
      else $error("accumulate sum wrong");
   chk_clear_op: assert property (start && engine_config.clear_accumulator && !cfg_wr
      |=> accumulator == 40'h0 && engine_flags == 4'h0 && !engine_config.clear_accumulator)
      else $error("clear did not act");
   chk_flag_sign: assert property (start |-> ##2 engine_flags.negative_flag
      == accumulator[39] && engine_flags.zero_flag == (accumulator == 40'h0))
      else $error("sign or zero flag wrong");
   chk_ho_hold: assert property (start && engine_config.multiply_only_select |-> ##2
      engine_flags.high_overflow_flag == $past(engine_flags.high_overflow_flag))
      else $error("high overflow changed");
   chk_shift_move: assert property ((cfg_wr && cfg_wdata.shift_command && !busy && !start)
      ##1 !cfg_wr |=> !engine_config.shift_command && engine_flags == $past(engine_flags)
      && accumulator == ($past(engine_config.shift_direction) ? {$past(accumulator[39]),
      $past(accumulator[39:1])} : {$past(accumulator[38:0]), 1'b0}))
      else $error("shift result wrong");
   chk_round_op: assert property (start |-> ##3 rounded_result == rnd($past(accumulator),
      $past(engine_config.saturation_enable))) else $error("rounded result wrong");
endmodule

bind mace_engine mace_engine_props chk
(
   .core_clk(core_clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
   .opnd_wr(opnd_wr), .acc_wr(acc_wr), .engine_config(engine_config),
   .engine_flags(engine_flags), .operand_a(operand_a), .operand_b(operand_b),
   .accumulator(accumulator), .rounded_result(rounded_result), .busy(busy)
);

// >>> verif/mace_core_model.sv
// Model of the processor core issuing register writes to the engine.
// Assumes the bench calls its tasks from the first clock; one write per clock.
`timescale 1ns/1ps
module mace_core_model
(
   // Clock
   input  wire logic                 core_clk,
   // Writes toward the engine
   output logic                      cfg_wr,
   output mace_pkg::mace_cfg_type     cfg_wdata,
   output mace_pkg::mace_opnd_wr_type opnd_wr,
   output mace_pkg::mace_acc_wr_type  acc_wr
);
   import mace_pkg::*;
   // One clock of writes; unused data toggles so it is never trusted
   task automatic cyc(input logic cw, input logic [5:0] c, input logic [2:0] st,
                      input logic [15:0] a, input logic [7:0] b, input logic [4:0] bw);
      @(posedge core_clk);
      cfg_wr    <= cw;
      cfg_wdata <= cw ? c : ~cfg_wdata;
      opnd_wr   <= {st, st[2] ? a : ~opnd_wr.operand_a, (|st[1:0]) ? b : ~opnd_wr.operand_b_byte};
      acc_wr    <= {bw, (|bw) ? b : ~acc_wr.byte_data};
   endtask
   task automatic idle();
      cyc(1'b0, 6'h00, 3'b000, 16'h0000, 8'h00, 5'h00);
   endtask
   task automatic wr_cfg(input logic [5:0] c);
      cyc(1'b1, c, 3'b000, 16'h0000, 8'h00, 5'h00);
   endtask
   // Operands A and B high before the starting low byte
   task automatic mac(input logic [15:0] a, input logic [15:0] b);
      cyc(1'b0, 6'h00, 3'b100, a, 8'h00, 5'h00);
      cyc(1'b0, 6'h00, 3'b010, 16'h0000, b[15:8], 5'h00);
      cyc(1'b0, 6'h00, 3'b001, 16'h0000, b[7:0], 5'h00);
   endtask
   task automatic wr_bl(input logic [7:0] b);
      cyc(1'b0, 6'h00, 3'b001, 16'h0000, b, 5'h00);
   endtask
   task automatic wr_bh(input logic [7:0] b);
      cyc(1'b0, 6'h00, 3'b010, 16'h0000, b, 5'h00);
   endtask
   // Accumulator bytes, top byte first, byte 0 last
   task automatic wr_acc(input logic [39:0] v);
      for (int i = 4; i >= 0; i--)
         cyc(1'b0, 6'h00, 3'b000, 16'h0000, v[i*8+:8], 5'(1 << i));
   endtask
endmodule

// >>> verif/mace_engine_tb_top.sv
// Self-checking bench for the multiply accumulate engine.
// Assumes the core model drives all writes; the checker is bound in.
`timescale 1ns/1ps
module mace_engine_tb_top;
   import mace_pkg::*;
   logic             core_clk;
   logic             rstn;
   logic             cfg_wr;
   mace_cfg_type     cfg_wdata;
   mace_opnd_wr_type opnd_wr;
   mace_acc_wr_type  acc_wr;
   mace_cfg_type     engine_config;
   mace_flags_type   engine_flags;
   logic [15:0]      operand_a;
   logic [15:0]      operand_b;
   logic [39:0]      accumulator;
   logic [15:0]      rounded_result;
   logic             busy;
   int               miscompares = 0;
   int               total_checks = 0;
   // Accumulator, saturation bit, expected rounded result
   localparam logic [56:0] RTAB [8] = '{{40'h0000018000, 1'b0, 16'h0002},
      {40'h0000028000, 1'b0, 16'h0002}, {40'h0000027fff, 1'b0, 16'h0002},
      {40'h0000028001, 1'b0, 16'h0003}, {40'h007fffffff, 1'b1, 16'h7fff},
      {40'h007fffffff, 1'b0, 16'h8000}, {40'hfe00000000, 1'b1, 16'h8000},
      {40'hfe00000000, 1'b0, 16'h0000}};
   mace_core_model core
   (
      .core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .opnd_wr(opnd_wr), .acc_wr(acc_wr)
   );
   mace_engine uut
   (
      .core_clk(core_clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .opnd_wr(opnd_wr), .acc_wr(acc_wr), .engine_config(engine_config),
      .engine_flags(engine_flags), .operand_a(operand_a), .operand_b(operand_b),
      .accumulator(accumulator), .rounded_result(rounded_result), .busy(busy)
   );
   // 25 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // ==========================
   // Helpers
   // ==========================
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pause(input int n);
      repeat (n) core.idle();
      #1;
   endtask
   task automatic test_done();
      if (miscompares == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========================
   // Scenarios
   // ==========================
   task automatic t_frac_mac();
      core.wr_cfg(6'h0a);
      core.mac(16'h4000, 16'h2000);
      core.wr_bh(8'he0);
      core.wr_bl(8'h00);
      pause(3);
      check(accumulator, 40'h0);
      check(engine_flags, 4'h4);
      check(engine_config, 6'h02);
      check(rounded_result, 16'h0000);
   endtask
   task automatic t_mul_only();
      core.wr_cfg(6'h01);
      core.mac(16'h1234, 16'hfedc);
      pause(2);
      check(accumulator, 40'hffffeb3cb0);
      check(rounded_result, 16'h0000);
      check(engine_flags, 4'h1);
      check(operand_a, 16'h1234);
      check(operand_b, 16'hfedc);
      pause(1);
      check(rounded_result, 16'hffeb);
   endtask
   task automatic t_overflow();
      core.wr_acc(40'h7fffffffff);
      core.wr_cfg(6'h00);
      core.mac(16'h7fff, 16'h7fff);
      pause(2);
      check(accumulator, 40'h803fff0000);
      check(engine_flags, 4'hb);
      core.wr_cfg(6'h01);
      core.mac(16'h0001, 16'h0001);
      pause(2);
      check(engine_flags, 4'ha);
      core.wr_cfg(6'h09);
      core.mac(16'h0002, 16'h0003);
      pause(1);
      check(accumulator, 40'h0);
      check(engine_flags, 4'h0);
      check(engine_config, 6'h01);
      pause(1);
      check(accumulator, 40'h6);
      check(engine_flags, 4'h0);
   endtask
   task automatic t_shift();
      core.wr_acc(40'h4088442211);
      core.wr_cfg(6'h20);
      pause(2);
      check(accumulator, 40'h8110884422);
      check(engine_config.shift_command, 1'b0);
      pause(1);
      check(rounded_result, 16'h1088);
      core.wr_cfg(6'h30);
      core.wr_cfg(6'h30);
      pause(3);
      check(accumulator, 40'he044221108);
      check(rounded_result, 16'h4422);
   endtask
   task automatic t_round();
      for (int i = 0; i < 8; i++)
      begin
         core.wr_cfg({3'b000, RTAB[i][16], 2'b00});
         core.wr_acc(RTAB[i][56:17]);
         pause(2);
         check(rounded_result, RTAB[i][15:0]);
         check(accumulator, RTAB[i][56:17]);
      end
   endtask
   // ==========================
   // Main sequence and watchdog
   // ==========================
   initial
   begin
      rstn = 1'b0;
      repeat (12) core.idle();
      rstn <= 1'b1;
      #1;
      check({engine_config, engine_flags, busy, rounded_result}, 40'h0);
      check(accumulator, 40'h0);
      t_frac_mac();
      t_mul_only();
      t_shift();
      t_round();
      t_overflow();
      test_done();
   end
   initial
   begin
      repeat (1000) @(posedge core_clk);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end
endmodule
